// ===== src/ssie_top.sv
// Purpose: Evaluate safety contact groups into enable outputs
// Assumes: Contacts are asynchronous pins; one 40 MHz clock
// Notes: Each timed monitor has its own window machine and counter
// Notes on behaviour
// (R1) Dual-closed/open monitor faults on 3 s timeout
// (R2) Dual monitor window starts on any activity
// (R3) Dual target: both closed high, open low
// (R4) Triple monitor faults if others lag 3 s
// (R5) Triple enable only with all three high
// (R6) Two-hand closed/open pair syncs within 0.5 s
// (R7) Two-hand open pair syncs within 0.5 s
// (R8) No glitch check, no release window
// (R9) Open pair enables only with both high
// (R10) Both-released condition rearms the two-hand pair monitor
// (R11) Two-position selector: exactly one input high
// (R12) Three-position selector: exactly one input high
// (R13) Windows are parameterised cycle counters, reset
`timescale 1ns/1ps
`include "ssie_defs.svh"
module ssie_top
  import ssie_pkg::*;
#(
  parameter logic [`SSIE_CNT_W-1:0] CONTACT_WIN_CYC = `SSIE_CNT_W'(`SSIE_CONTACT_WIN_CYC),
  parameter logic [`SSIE_CNT_W-1:0] TWO_HAND_WIN_CYC = `SSIE_CNT_W'(`SSIE_TWO_HAND_WIN_CYC)
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_dual_contacts,
  input wire logic [2:0] i_triple_contacts,
  input wire logic [3:0] i_two_hand_co_contacts,
  input wire logic [1:0] i_two_hand_pair_contacts,
  input wire logic [1:0] i_sel2_contacts,
  input wire logic [2:0] i_sel3_contacts,
  output logic o_dual_enable,
  output logic o_dual_fault,
  output logic o_triple_enable,
  output logic o_triple_fault,
  output logic o_triple_and_enable,
  output logic o_two_hand_co_enable,
  output logic o_two_hand_pair_enable,
  output logic [1:0] o_sel2_enable,
  output logic [2:0] o_sel3_enable
);
  localparam int NIN = 17;
  localparam int NMON = 4;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  // Two-stage synchronisers; reset to released levels so no false window follows reset
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= `SSIE_SYNC_IDLE;
      sync2_r <= `SSIE_SYNC_IDLE;
    end else begin
      sync1_r <= {i_sel3_contacts, i_sel2_contacts, i_two_hand_pair_contacts,
                  i_two_hand_co_contacts, i_triple_contacts, i_dual_contacts};
      sync2_r <= sync1_r;
    end
  end
  logic [2:0] dual_in;
  logic [2:0] tri_in;
  logic [3:0] thc_in;
  logic [1:0] thp_in;
  logic [1:0] s2_in;
  logic [2:0] s3_in;
  assign {s3_in, s2_in, thp_in, thc_in, tri_in, dual_in} = sync2_r;

  function automatic logic one_hot3(input logic [2:0] v, input int k);
    one_hot3 = (v == 3'(1 << k));
  endfunction : one_hot3

  // Per-monitor start, target and release conditions
  logic [NMON-1:0] win_start;
  logic [NMON-1:0] target;
  logic [NMON-1:0] released;
  logic [NMON-1:0] restart_ok;
  logic [`SSIE_CNT_W-1:0] win_len [NMON];
  assign win_start[0] = dual_in[0] | dual_in[1] | ~dual_in[2]; // [R2]
  assign target[0] = dual_in[0] & dual_in[1] & ~dual_in[2]; // [R3]
  assign released[0] = ~win_start[0];
  assign restart_ok[0] = 1'b0;
  assign win_start[1] = |tri_in; // [R5]
  assign target[1] = &tri_in; // [R5]
  assign released[1] = ~win_start[1];
  assign restart_ok[1] = 1'b0;
  // Two-hand closed/open: contacts 0,2 open type, 1,3 closed type
  assign win_start[2] = ~thc_in[0] | thc_in[1] | ~thc_in[2] | thc_in[3]; // [R6]
  assign target[2] = ~thc_in[0] & thc_in[1] & ~thc_in[2] & thc_in[3]; // [R6]
  assign released[2] = thc_in[0] & ~thc_in[1] & thc_in[2] & ~thc_in[3];
  assign restart_ok[2] = 1'b1; // [R8]
  assign win_start[3] = |thp_in; // [R9]
  assign target[3] = &thp_in; // [R9]
  assign released[3] = ~thp_in[0] & ~thp_in[1]; // [R10]
  assign restart_ok[3] = 1'b1; // [R8]
  assign win_len[0] = CONTACT_WIN_CYC;
  assign win_len[1] = CONTACT_WIN_CYC;
  assign win_len[2] = TWO_HAND_WIN_CYC;
  assign win_len[3] = TWO_HAND_WIN_CYC;

  ssie_mon_e st_r [NMON];
  logic [`SSIE_CNT_W-1:0] cnt_r [NMON];
  logic [NMON-1:0] en;
  logic [NMON-1:0] flt;

  genvar g;
  generate
    for (g = 0; g < NMON; g++) begin : g_mon
      // Window state; two-hand monitors rearm on full release only
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          st_r[g] <= SSIE_IDLE;
        end else begin
          case (st_r[g])
            SSIE_IDLE: begin
              if (target[g]) st_r[g] <= SSIE_ON;
              else if (win_start[g]) st_r[g] <= SSIE_WAIT;
            end
            SSIE_WAIT: begin
              if (target[g]) st_r[g] <= SSIE_ON;
              else if (released[g]) st_r[g] <= SSIE_IDLE; // [R8]
              else if (cnt_r[g] >= win_len[g] - 1) st_r[g] <= SSIE_FAULT; // [R1] [R4] [R6] [R7]
            end
            SSIE_ON: begin
              if (released[g]) st_r[g] <= SSIE_IDLE; // [R8]
              else if (!target[g]) st_r[g] <= restart_ok[g] ? SSIE_FAULT : SSIE_WAIT;
            end
            SSIE_FAULT: begin
              if (released[g]) st_r[g] <= SSIE_IDLE;
            end
            default: st_r[g] <= SSIE_IDLE;
          endcase
        end
      end
      // Window counter runs only while waiting
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          cnt_r[g] <= '0; // [R13]
        end else if (st_r[g] == SSIE_WAIT) begin
          cnt_r[g] <= cnt_r[g] + `SSIE_CNT_W'(1); // [R13]
        end else begin
          cnt_r[g] <= '0;
        end
      end
      assign en[g] = (st_r[g] == SSIE_ON) & target[g];
      assign flt[g] = (st_r[g] == SSIE_FAULT);
    end
  endgenerate

  // Registered enable and fault outputs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dual_enable <= 1'b0;
      o_dual_fault <= 1'b0;
      o_triple_enable <= 1'b0;
      o_triple_fault <= 1'b0;
      o_triple_and_enable <= 1'b0;
      o_two_hand_co_enable <= 1'b0;
      o_two_hand_pair_enable <= 1'b0;
      o_sel2_enable <= 2'h0;
      o_sel3_enable <= 3'h0;
    end else begin
      o_dual_enable <= en[0]; // [R1] [R3]
      o_dual_fault <= flt[0]; // [R1]
      o_triple_enable <= en[1]; // [R4] [R5]
      o_triple_fault <= flt[1]; // [R4]
      o_triple_and_enable <= &tri_in; // [R5]
      o_two_hand_co_enable <= en[2]; // [R6]
      o_two_hand_pair_enable <= en[3]; // [R7] [R9]
      o_sel2_enable <= {~s2_in[0] & s2_in[1], s2_in[0] & ~s2_in[1]}; // [R11]
      o_sel3_enable <= {one_hot3(s3_in, 2), one_hot3(s3_in, 1), one_hot3(s3_in, 0)}; // [R12]
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_DUAL_NEEDS_TARGET: assert property (o_dual_enable |-> $past(target[0])) // [R3]
    else $error("Dual enable without target state");
  AST_DUAL_TIMEOUT: assert property (st_r[0] == SSIE_WAIT && !target[0] && !released[0]
      && cnt_r[0] == CONTACT_WIN_CYC - 1 |=> st_r[0] == SSIE_FAULT ##1 o_dual_fault) // [R1]
    else $error("Dual window expiry did not fault");
  AST_DUAL_START: assert property (st_r[0] == SSIE_IDLE && win_start[0] && !target[0]
      |=> st_r[0] == SSIE_WAIT) // [R2]
    else $error("Dual window did not start");
  AST_TRIPLE_TIMEOUT: assert property (st_r[1] == SSIE_WAIT && !target[1] && !released[1]
      && cnt_r[1] == CONTACT_WIN_CYC - 1 |=> ##1 o_triple_fault && !o_triple_enable) // [R4]
    else $error("Triple window expiry did not fault");
  AST_TRIPLE_AND: assert property (o_triple_and_enable == $past(&tri_in)) // [R5]
    else $error("Triple and output wrong");
  AST_TH_CO_TIMEOUT: assert property (st_r[2] == SSIE_WAIT && !target[2] && !released[2]
      && cnt_r[2] == TWO_HAND_WIN_CYC - 1 |=> ##1 !o_two_hand_co_enable [*2]) // [R6]
    else $error("Two-hand window expiry did not block");
  AST_TH_PAIR_BOTH: assert property (o_two_hand_pair_enable |-> $past(&thp_in)) // [R9]
    else $error("Two-hand enable without both contacts");
  AST_TH_PAIR_LATE: assert property (st_r[3] == SSIE_FAULT && !released[3] |=> !en[3]) // [R7]
    else $error("Late two-hand press enabled");
  AST_TH_RELEASE: assert property (released[3] |=> st_r[3] == SSIE_IDLE) // [R8] [R10]
    else $error("Release did not rearm two-hand");
  AST_SEL2: assert property ($countones(o_sel2_enable) <= 1 && (o_sel2_enable[0] == $past(s2_in == 2'h1))) // [R11]
    else $error("Selector two decode wrong");
  AST_SEL3: assert property ($countones(o_sel3_enable) <= 1 && (o_sel3_enable[1] == $past(s3_in == 3'h2))) // [R12]
    else $error("Selector three decode wrong");
  AST_CNT_RESET: assert property (st_r[0] != SSIE_WAIT |=> cnt_r[0] == '0) // [R13]
    else $error("Window counter not cleared");
  COV_DUAL_ON: cover property (o_dual_enable);
  COV_DUAL_FAULT: cover property (o_dual_fault);
  COV_TH_PAIR_ON: cover property (o_two_hand_pair_enable);
  COV_SEL3: cover property (o_sel3_enable[2]);
  COV_TH_CO_ON: cover property (o_two_hand_co_enable);
  AST_TRIPLE_START: assert property (st_r[1] == SSIE_IDLE && win_start[1] && !target[1]
      |=> st_r[1] == SSIE_WAIT) // [R5]
    else $error("Triple window did not start");
  AST_TH_CO_BOTH: assert property (o_two_hand_co_enable |-> $past(thc_in == 4'ha)) // [R6]
    else $error("Two-hand enable without all contacts pressed");
  AST_TH_CO_RELEASE: assert property (released[2] |=> st_r[2] == SSIE_IDLE) // [R8]
    else $error("Release did not rearm closed/open two-hand");
  AST_TH_PAIR_TIMEOUT: assert property (st_r[3] == SSIE_WAIT && !target[3] && !released[3]
      && cnt_r[3] == TWO_HAND_WIN_CYC - 1 |=> st_r[3] == SSIE_FAULT ##1 !o_two_hand_pair_enable) // [R7]
    else $error("Two-hand pair window expiry did not block");
  AST_SEL2_HI: assert property (o_sel2_enable[1] == $past(s2_in == 2'h2)) // [R11]
    else $error("Selector two upper decode wrong");
  AST_SEL3_ALL: assert property (o_sel3_enable == $past({s3_in == 3'h4, s3_in == 3'h2, s3_in == 3'h1})) // [R12]
    else $error("Selector three full decode wrong");
endmodule : ssie_top

// ===== src/ssie_defs.svh
// Purpose: Constants for the safety switch input evaluator
// Assumes: 40 MHz core clock
// Notes: Window counts derived from times in milliseconds
`ifndef SSIE_DEFS_SVH
`define SSIE_DEFS_SVH
`define SSIE_CLK_HZ 40000000
`define SSIE_CONTACT_WIN_MS 3000
`define SSIE_TWO_HAND_WIN_MS 500
`define SSIE_CONTACT_WIN_CYC ((`SSIE_CLK_HZ / 1000) * `SSIE_CONTACT_WIN_MS)
`define SSIE_TWO_HAND_WIN_CYC ((`SSIE_CLK_HZ / 1000) * `SSIE_TWO_HAND_WIN_MS)
`define SSIE_CNT_W 27
// Released levels of all contact pins, in synchroniser bit order
`define SSIE_SYNC_IDLE 17'h00144
`endif

// ===== src/ssie_pkg.sv
// Purpose: Types for the safety switch input evaluator
// Assumes: Nothing
// Notes: Monitor state shared by all timed monitors
package ssie_pkg;
  typedef enum logic [1:0] {
    SSIE_IDLE,
    SSIE_WAIT,
    SSIE_ON,
    SSIE_FAULT
  } ssie_mon_e;
endpackage : ssie_pkg

// ===== dv/ssie_contacts_model.sv
// Purpose: Field contact model with prompt and slow contacts
// Assumes: Lag counted in core clock cycles
// Notes: Masked contacts follow the commanded level late
`timescale 1ns/1ps
module ssie_contacts_model (
  input wire logic i_core_clk,
  input wire logic [16:0] i_level,
  input wire logic [16:0] i_lag_mask,
  input wire logic [7:0] i_lag,
  output logic [16:0] o_contacts
);
  logic [16:0] slow_r = '0;
  int cnt = 0;
  // Slow contacts take the new level after the lag
  always @(posedge i_core_clk) begin
    if (slow_r !== i_level) begin
      if (cnt >= int'(i_lag)) begin
        slow_r <= i_level;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end else begin
      cnt <= 0;
    end
  end
  assign o_contacts = (i_level & ~i_lag_mask) | (slow_r & i_lag_mask);
endmodule : ssie_contacts_model

// ===== dv/test_safety_switch_input_evaluator.sv
// Purpose: Self-checking bench for the safety switch input evaluator
// Assumes: Windows shortened to 20 and 10 cycles
// Notes: Expectations computed from levels and lags in the bench
`timescale 1ns/1ps
module test_safety_switch_input_evaluator;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [16:0] lv = 17'h00144;
  logic [16:0] msk = '0;
  logic [16:0] c;
  logic [7:0] lag = '0;
  logic de, df, te, tf, ta, ce, pe;
  logic [1:0] s2;
  logic [2:0] s3;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32520;
  ssie_contacts_model ssie_contacts_model_i (.i_core_clk(i_core_clk), .i_level(lv), .i_lag_mask(msk),
    .i_lag(lag), .o_contacts(c));
  ssie_top #(.CONTACT_WIN_CYC(27'h14), .TWO_HAND_WIN_CYC(27'ha)) ssie_top_i (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_dual_contacts(c[2:0]), .i_triple_contacts(c[5:3]),
    .i_two_hand_co_contacts(c[9:6]), .i_two_hand_pair_contacts(c[11:10]), .i_sel2_contacts(c[13:12]),
    .i_sel3_contacts(c[16:14]), .o_dual_enable(de), .o_dual_fault(df), .o_triple_enable(te),
    .o_triple_fault(tf), .o_triple_and_enable(ta), .o_two_hand_co_enable(ce), .o_two_hand_pair_enable(pe),
    .o_sel2_enable(s2), .o_sel3_enable(s3));
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : cyc
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk_mon(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_mon
  task automatic chk_dec(string n, logic [2:0] e, logic [2:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_dec
  function automatic logic [1:0] mon_out(int k);
    case (k)
      0: return {df, de};
      1: return {tf, te};
      2: return {1'b0, ce};
      default: return {1'b0, pe};
    endcase
  endfunction : mon_out
  // Idle, press with one or two late contacts, check, then release fully
  task automatic tmon(int k, logic [16:0] t, logic [16:0] m, int l, int w);
    logic [1:0] o;
    lv = 17'h00144;
    lag = '0;
    cyc(6);
    msk = m;
    lag = 8'(l);
    lv = t;
    cyc(l + 8);
    o = mon_out(k);
    chk_mon("enable", l < w, o[0]);
    chk_mon("fault", k < 2 && l >= w, o[1]);
    lv = 17'h00144;
    lag = '0;
    cyc(6);
    o = mon_out(k);
    chk_mon("released", 1'b0, o[0] | o[1]);
    $display("monitor %0d lag %0d done", k, l);
  endtask : tmon
  initial begin
    logic [31:0] r;
    logic [1:0] e2;
    cyc(5);
    i_resetn = 1'b1;
    cyc(2);
    tmon(0, 17'h00143, 17'h00002, 5, 20);
    tmon(0, 17'h00143, 17'h00004, 40, 20);
    tmon(1, 17'h0017c, 17'h00020, 5, 20);
    tmon(1, 17'h0017c, 17'h00020, 40, 20);
    tmon(2, 17'h00284, 17'h00300, 3, 10);
    tmon(2, 17'h00284, 17'h00300, 20, 10);
    tmon(3, 17'h00d44, 17'h00800, 3, 10);
    tmon(3, 17'h00d44, 17'h00800, 20, 10);
    msk = '0;
    repeat (64) begin
      r = $random(seed);
      lv = 17'h00144 | {r[4:0], 6'h00, r[7:5], 3'h0};
      cyc(5);
      e2 = {r[1] & ~r[0], r[0] & ~r[1]};
      chk_dec("sel2", {1'b0, e2}, {1'b0, s2});
      chk_dec("sel3", ($countones(r[4:2]) == 1) ? r[4:2] : 3'h0, s3);
      chk_dec("and3", {2'h0, &r[7:5]}, {2'h0, ta});
    end
    $display("decoder test done");
    end_of_test();
  end
  initial begin
    #125000;
    bad_count++;
    $display("[ERR] watchdog expected finish seen hang");
    end_of_test();
  end
endmodule : test_safety_switch_input_evaluator
